// ---- hw/cer_regs.sv ----
`timescale 1ns/1ps
module cer_regs
  import cer_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic link_reset_in,
  input wire logic global_reset_input_in,
  input wire logic corr_report_enable_in,
  input wire cer_event_t event_in,
  input wire cer_cfg_req_t cfg_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  output logic corr_msg_out,
  output logic header_log_load_out,
  output logic first_err_update_out,
  output logic [4:0] first_err_ptr_out
);

  // ***************************************************************************
  // Reset and event vector
  // ***************************************************************************

  // The link and global resets come from pins, so each passes two flip-flops first.
  // The two cycles of delay are far shorter than any reset that software could notice.
  logic [1:0] link_reset_sync;
  logic [1:0] global_reset_sync;
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      link_reset_sync <= 2'b00;
      global_reset_sync <= 2'b00;
    end
    else
    begin
      link_reset_sync <= {link_reset_sync[0], link_reset_in};
      global_reset_sync <= {global_reset_sync[0], global_reset_input_in};
    end
  end

  // Power-on, link and global reset all return the fields to defaults; only second stages are read.
  wire any_reset = reset_in | link_reset_sync[1] | global_reset_sync[1]; // R14
  logic [31:0] flags;
  logic [31:0] suppress;
  logic [31:0] raw_events;
  logic [31:0] recorded;
  logic [31:0] next_flags;
  logic [31:0] next_suppress;
  wire wr_flags = cfg_in.wr && (cfg_in.addr == CER_FLAGS_OFFSET);
  wire wr_suppress = cfg_in.wr && (cfg_in.addr == CER_SUPPRESS_OFFSET);
  wire rd_flags = cfg_in.rd && (cfg_in.addr == CER_FLAGS_OFFSET);
  wire rd_suppress = cfg_in.rd && (cfg_in.addr == CER_SUPPRESS_OFFSET);

  // Spread the event pulses onto their status bit positions.
  always_comb
  begin
    raw_events = '0;
    raw_events[CER_ADVISORY_BIT] = event_in.advisory_nonfatal; // R3
    raw_events[CER_REPLAY_TMO_BIT] = event_in.replay_timer_expired; // R4
    raw_events[CER_REPLAY_ROLL_BIT] = event_in.replay_rollover; // R5
    raw_events[CER_CORRUPT_LINK_PACKET_BIT] = event_in.decode_err_in_dllp; // R6
    raw_events[CER_CORRUPT_TRANSACTION_PACKET_BIT] = event_in.decode_err_in_tlp; // R7
    // Any decode error also raises the receiver error, so the typed bits imply it.
    raw_events[CER_RX_ERR_BIT] = event_in.decode_err_any | event_in.decode_err_in_dllp
      | event_in.decode_err_in_tlp; // R8
  end

  // ***************************************************************************
  // Status and mask update
  // ***************************************************************************

  // A masked error is not recorded at all; set beats a same-cycle clear.
  assign recorded = raw_events & ~suppress & CER_IMPL_BITS; // R10 R13
  assign next_flags = ((flags & ~(wr_flags ? cfg_in.wdata : 32'h0000_0000)) | recorded)
    & CER_IMPL_BITS; // R1 R9
  assign next_suppress = wr_suppress ? (cfg_in.wdata & CER_IMPL_BITS) : suppress; // R9

  // Sticky flags and mask bits.
  always_ff @(posedge sys_clk_in)
  begin
    if (any_reset)
    begin
      flags <= CER_FLAGS_RESET; // R2
      suppress <= CER_SUPPRESS_RESET; // R11 R12
    end
    else
    begin
      flags <= next_flags;
      suppress <= next_suppress;
    end
  end

  // ***************************************************************************
  // Read path
  // ***************************************************************************

  // Unmapped offsets read zero; the answer follows the request by one cycle.
  wire [31:0] rd_mux = rd_flags ? flags : (rd_suppress ? suppress : 32'h0000_0000);

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_rvalid_out <= 1'b0;
    end
    else
    begin
      cfg_rdata_out <= rd_mux;
      cfg_rvalid_out <= cfg_in.rd;
    end
  end

  // ***************************************************************************
  // Reporting side effects
  // ***************************************************************************

  // The header log and pointer belong to other blocks; we only issue their strobes and a zero pointer value.
  wire any_recorded = |recorded;
  logic first_seen;
  always_ff @(posedge sys_clk_in)
  begin
    if (any_reset)
    begin
      corr_msg_out <= 1'b0;
      header_log_load_out <= 1'b0;
      first_err_update_out <= 1'b0;
      first_err_ptr_out <= 5'h00;
      first_seen <= 1'b0;
    end
    else
    begin
      corr_msg_out <= any_recorded & corr_report_enable_in; // R16 R10
      header_log_load_out <= any_recorded; // R10
      first_err_update_out <= any_recorded & ~first_seen; // R10
      if (any_recorded && !first_seen)
      begin
        // The pointer names a position in the uncorrectable register; correctable
        // errors carry no such class, so the position stays at zero.
        first_err_ptr_out <= 5'h00; // R15
        first_seen <= 1'b1;
      end
    end
  end

  // ***************************************************************************
  // Assertions
  // ***************************************************************************
  // Each unmasked event lands in its own flag on the edge after it arrives.
  a_flag_sets: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R3
    (event_in.advisory_nonfatal && !suppress[CER_ADVISORY_BIT]) |=> flags[CER_ADVISORY_BIT])
    else $error("advisory flag not set");
  a_tmo_sets: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R4
    (event_in.replay_timer_expired && !suppress[CER_REPLAY_TMO_BIT]) |=> flags[CER_REPLAY_TMO_BIT])
    else $error("replay timer flag not set");
  a_roll_sets: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R5
    (event_in.replay_rollover && !suppress[CER_REPLAY_ROLL_BIT]) |=> flags[CER_REPLAY_ROLL_BIT])
    else $error("rollover flag not set");
  a_dllp_sets: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R6
    (event_in.decode_err_in_dllp && !suppress[CER_CORRUPT_LINK_PACKET_BIT])
    |=> flags[CER_CORRUPT_LINK_PACKET_BIT])
    else $error("dllp flag not set");
  a_tlp_sets: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R7
    (event_in.decode_err_in_tlp && !suppress[CER_CORRUPT_TRANSACTION_PACKET_BIT])
    |=> flags[CER_CORRUPT_TRANSACTION_PACKET_BIT])
    else $error("tlp flag not set");
  a_rx_sets: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R8
    (event_in.decode_err_any && !suppress[CER_RX_ERR_BIT]) |=> flags[CER_RX_ERR_BIT])
    else $error("receiver flag not set");

  // Software clears only what it writes as one; everything else holds unless an event arrives.
  a_zero_keeps: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R1
    (wr_flags && flags[CER_RX_ERR_BIT] && !cfg_in.wdata[CER_RX_ERR_BIT]) |=> flags[CER_RX_ERR_BIT])
    else $error("flag lost on zero write");
  a_clear_one: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R1
    (wr_flags && cfg_in.wdata[CER_RX_ERR_BIT] && !raw_events[CER_RX_ERR_BIT]) |=> !flags[CER_RX_ERR_BIT])
    else $error("flag survived a clear");
  a_flags_hold: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R1
    (raw_events == 32'h0000_0000 && !wr_flags) |=> flags == $past(flags))
    else $error("flag changed without cause");

  // Masking stops the flag and every side effect; reserved bits never rise.
  a_mask_blocks: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R10
    (suppress[CER_CORRUPT_TRANSACTION_PACKET_BIT] && !flags[CER_CORRUPT_TRANSACTION_PACKET_BIT] && !wr_suppress)
    |=> !flags[CER_CORRUPT_TRANSACTION_PACKET_BIT])
    else $error("masked flag got set");
  a_masked_silent: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R10
    ((raw_events & ~suppress) == 32'h0000_0000)
    |=> (!corr_msg_out && !header_log_load_out && !first_err_update_out))
    else $error("masked error reported");
  a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R9
    ((flags | suppress) & ~CER_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved bit nonzero");
  a_mask_write: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R13
    wr_suppress |=> suppress == ($past(cfg_in.wdata) & CER_IMPL_BITS))
    else $error("mask write lost");

  // Reset values, and the strobes that follow a recorded error.
  a_reset_values: assert property (@(posedge sys_clk_in) // R2 R11 R14
    any_reset |=> (flags == CER_FLAGS_RESET && suppress == CER_SUPPRESS_RESET))
    else $error("reset values wrong");
  a_msg_gated: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R16
    (any_recorded && corr_report_enable_in) |=> corr_msg_out)
    else $error("message not sent");
  a_log_follows: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R10 R16
    (|(raw_events & ~suppress)) |=> (header_log_load_out && corr_msg_out == $past(corr_report_enable_in)))
    else $error("header log strobe missing");
  a_first_update: assert property (@(posedge sys_clk_in) disable iff (any_reset) // R10 R15
    (any_recorded && !first_seen) |=> first_err_update_out)
    else $error("first error update missing");

  // Main scenarios that the bench should reach.
  c_clear_flag: cover property (@(posedge sys_clk_in) disable iff (any_reset)
    flags[CER_RX_ERR_BIT] ##1 wr_flags && cfg_in.wdata[CER_RX_ERR_BIT] ##1 !flags[CER_RX_ERR_BIT]);
  c_set_clear_race: cover property (@(posedge sys_clk_in) disable iff (any_reset)
    wr_flags && cfg_in.wdata[CER_REPLAY_TMO_BIT] && recorded[CER_REPLAY_TMO_BIT]);
  c_unmask_adv: cover property (@(posedge sys_clk_in) disable iff (any_reset)
    !suppress[CER_ADVISORY_BIT] && event_in.advisory_nonfatal);
  c_masked_event: cover property (@(posedge sys_clk_in) disable iff (any_reset)
    |(raw_events & suppress));
  c_first_report: cover property (@(posedge sys_clk_in) disable iff (any_reset)
    first_err_update_out);

endmodule

// ---- hw/cer_pkg.sv ----
// Operation
// R1: A status flag clears only when software writes one to it; zero leaves it.
// R2: Status register sits at offset 110h and reads zero after reset.
// R3: Advisory non-fatal error report sets status bit 13.
// R4: Replay timer expiry with unacknowledged packet sets status bit 12.
// R5: Replay count rollover with unacknowledged packet sets status bit 8.
// R6: An 8b/10b error while receiving a DLLP sets status bit 7.
// R7: An 8b/10b error while receiving a TLP sets status bit 6.
// R8: Any 8b/10b error sets status bit 0 regardless of packet type.
// R9: Unimplemented bits of status and mask read zero and ignore writes.
// R10: A set mask bit blocks flag, message, header log load and pointer update.
// R11: Mask register sits at offset 114h and resets to 0000 2000h.
// R12: Mask bit 13 defaults to one, masking advisory errors after reset.
// R13: Mask bits 12, 8, 7, 6, 0 gate their flags and default to zero.
// R14: Fields reset on link, global or power-on reset, and nothing else.
// R15: First error pointer is a 5-bit position in the uncorrectable status register.
// R16: An unmasked recorded error sends a correctable message when reporting is enabled.
package cer_pkg;

  // ***************************************************************************
  // Register map and field layout
  // ***************************************************************************
  localparam logic [11:0] CER_FLAGS_OFFSET = 12'h110;
  localparam logic [11:0] CER_SUPPRESS_OFFSET = 12'h114;
  localparam logic [31:0] CER_FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] CER_SUPPRESS_RESET = 32'h0000_2000;
  localparam logic [31:0] CER_IMPL_BITS = 32'h0000_31c1;
  localparam int CER_ADVISORY_BIT = 13;
  localparam int CER_REPLAY_TMO_BIT = 12;
  localparam int CER_REPLAY_ROLL_BIT = 8;
  localparam int CER_CORRUPT_LINK_PACKET_BIT = 7;
  localparam int CER_CORRUPT_TRANSACTION_PACKET_BIT = 6;
  localparam int CER_RX_ERR_BIT = 0;

  // One cycle pulses reported by the link and physical layers.
  typedef struct packed {
    logic advisory_nonfatal;
    logic replay_timer_expired;
    logic replay_rollover;
    logic decode_err_in_dllp;
    logic decode_err_in_tlp;
    logic decode_err_any;
  } cer_event_t;

  // Configuration access from the extended configuration space decoder.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cer_cfg_req_t;

endpackage

// ---- verification/cer_link_model.sv ----
`timescale 1ns/1ps
// ****
// Link and physical layer stand-in
// ****
module cer_link_model
  import cer_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic fire_in,
  input wire cer_event_t sel_in,
  output cer_event_t event_out
);
  // The layers below report each error as a single-cycle pulse, never a level.
  always_ff @(posedge sys_clk_in)
  begin
    event_out <= fire_in ? sel_in : '0;
  end
endmodule

// ---- verification/correctable_error_reporting_bench.sv ----
`timescale 1ns/1ps
module correctable_error_reporting_bench;
  import cer_pkg::*;
  // ****
  // Stimulus and observed signals
  // ****
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic link_reset_in = 1'b0;
  logic global_reset_input_in = 1'b0;
  logic corr_report_enable_in = 1'b1;
  cer_cfg_req_t cfg_in = '0;
  cer_event_t sel = '0;
  logic fire = 1'b0;
  cer_event_t event_w;
  logic [31:0] cfg_rdata_out;
  logic cfg_rvalid_out;
  logic corr_msg_out;
  logic header_log_load_out;
  logic first_err_update_out;
  logic [4:0] first_err_ptr_out;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] flag_exp [6] = '{32'h0001, 32'h0041, 32'h0081, 32'h0100, 32'h1000, 32'h2000};

  // Free-running clock; the ceiling is far above the 124 or so cycles the tests need.
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      close_out();
    end
  end

  cer_link_model u_model (.sys_clk_in(sys_clk_in), .fire_in(fire), .sel_in(sel), .event_out(event_w));
  cer_regs u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_reset_in(link_reset_in),
    .global_reset_input_in(global_reset_input_in), .corr_report_enable_in(corr_report_enable_in),
    .event_in(event_w), .cfg_in(cfg_in), .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
    .corr_msg_out(corr_msg_out), .header_log_load_out(header_log_load_out),
    .first_err_update_out(first_err_update_out), .first_err_ptr_out(first_err_ptr_out));

  // ****
  // Access tasks
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Each task idles one cycle at its end, so no strobe is driven twice in one step.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cfg_in <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk_in) #1;
    cfg_in <= '0;
    @(posedge sys_clk_in) #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    cfg_in <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge sys_clk_in) #1;
    check("rvalid", 32'(cfg_rvalid_out), 32'h1);
    check("rdata", cfg_rdata_out, exp);
    cfg_in <= '0;
    @(posedge sys_clk_in) #1;
  endtask
  // The strobes stand for one cycle, two edges after the request to the model.
  task automatic pulse(input cer_event_t e, input logic exp_log, input logic exp_msg, input logic exp_first);
    sel <= e;
    fire <= 1'b1;
    @(posedge sys_clk_in) #1;
    fire <= 1'b0;
    @(posedge sys_clk_in) #1;
    check("header_log_load", 32'(header_log_load_out), 32'(exp_log));
    check("corr_msg", 32'(corr_msg_out), 32'(exp_msg));
    check("first_err_update", 32'(first_err_update_out), 32'(exp_first));
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence: reset values, reserved bits, masking, each error kind, then the resets.
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    #1 reset_in <= 1'b0;
    rd(CER_FLAGS_OFFSET, 32'h0000_0000);
    rd(CER_SUPPRESS_OFFSET, 32'h0000_2000);
    rd(12'h118, 32'h0000_0000);
    $display("test reset values done");
    wr(CER_SUPPRESS_OFFSET, 32'hffff_ffff);
    rd(CER_SUPPRESS_OFFSET, 32'h0000_31c1);
    wr(CER_FLAGS_OFFSET, 32'hffff_ffff);
    pulse(cer_event_t'(6'h3f), 1'b0, 1'b0, 1'b0);
    rd(CER_FLAGS_OFFSET, 32'h0000_0000);
    wr(CER_SUPPRESS_OFFSET, 32'h0000_0000);
    $display("test masking done");
    for (int i = 0; i < 6; i++)
    begin
      corr_report_enable_in <= i[0];
      pulse(cer_event_t'(6'h01 << i), 1'b1, i[0], i == 0);
      wr(CER_FLAGS_OFFSET, 32'h0000_0000);
      rd(CER_FLAGS_OFFSET, flag_exp[i]);
      wr(CER_FLAGS_OFFSET, flag_exp[i]);
      rd(CER_FLAGS_OFFSET, 32'h0000_0000);
    end
    $display("test error kinds done");
    for (int j = 0; j < 2; j++)
    begin
      pulse(cer_event_t'(6'h01), 1'b1, 1'b1, j == 1);
      link_reset_in <= (j == 0);
      global_reset_input_in <= (j == 1);
      @(posedge sys_clk_in) #1;
      link_reset_in <= 1'b0;
      global_reset_input_in <= 1'b0;
      // The reset pins pass a two-stage synchroniser, so give it time to act.
      repeat (2) @(posedge sys_clk_in) #1;
      rd(CER_FLAGS_OFFSET, 32'h0000_0000);
      rd(CER_SUPPRESS_OFFSET, 32'h0000_2000);
      pulse(cer_event_t'(6'h20), 1'b0, 1'b0, 1'b0);
      rd(CER_FLAGS_OFFSET, 32'h0000_0000);
      wr(CER_SUPPRESS_OFFSET, 32'h0000_0000);
    end
    check("first_err_ptr", 32'(first_err_ptr_out), 32'h0);
    $display("test resets done");
    close_out();
  end
endmodule
